// >>> rtl/sbgt_timer.sv
// sixteen-bit general timer: register file, clock selection, counter and interrupt
`include "sbgt_map.svh"

module sbgt_timer (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // register port
    input  wire logic [7:0]          reg_addr,
    input  wire sbgt_pkg::sbgt_word_t reg_wdata,
    input  wire logic                reg_we,
    input  wire logic                reg_re,
    output sbgt_pkg::sbgt_word_t     reg_rdata,
    // pins
    input  wire logic                ext_clock_pin,
    // power state
    input  wire logic                cpu_idle,
    input  wire logic                cpu_sleep,
    // interrupt
    output logic                     irq
);
    import sbgt_pkg::*;

    // ==========================================================
    // state
    sbgt_ctrl_s ctrl_q;
    sbgt_ctrl_s ctrl_d;
    sbgt_word_t count_q;
    sbgt_word_t count_d;
    sbgt_word_t period_q;
    sbgt_word_t period_d;
    sbgt_word_t status_q;
    sbgt_word_t status_d;
    sbgt_word_t mask_q;
    sbgt_word_t mask_d;
    sbgt_word_t rdata_q;
    sbgt_word_t rdata_d;
    logic       irq_q;
    logic       irq_d;
    logic       int_ph_q;
    logic       int_ph_d;
    logic       pend_q;
    logic       pend_d;

    // ==========================================================
    // decode
    logic       wr_ctrl;
    logic       wr_count;
    logic       wr_period;
    logic       wr_mask;
    logic       rd_status;
    logic       halted;
    logic       int_tick;
    logic       ext_tick;
    logic       gate_mode;
    logic       match_set;
    logic       gate_set;
    sbgt_word_t st_set;
    logic       pin_level;
    logic       pin_rise;
    logic       pin_fall;

    sbgt_presc_if pl ();

    assign wr_ctrl   = reg_we & (reg_addr == `SBGT_OFF_CTRL);
    assign wr_count  = reg_we & (reg_addr == `SBGT_OFF_COUNT);
    assign wr_period = reg_we & (reg_addr == `SBGT_OFF_PERIOD);
    assign wr_mask   = reg_we & (reg_addr == `SBGT_OFF_MASK);
    assign rd_status = reg_re & (reg_addr == `SBGT_OFF_STATUS);

    // ==========================================================
    // pin synchroniser, used both as clock and as gate
    sbgt_pin_sync #(
        .STAGES (2)
    ) u_pin_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (ext_clock_pin),
        .level (pin_level),
        .rise  (pin_rise),
        .fall  (pin_fall)
    );

    // ==========================================================
    // clock source selection
    always_comb begin
        // idle halt stops the prescaler input and the gate event
        halted    = cpu_idle & ctrl_q.idle_halt;
        // internal clock stops in sleep
        int_tick  = int_ph_q & ~cpu_sleep;
        int_ph_d  = ~int_ph_q;
        gate_mode = ~ctrl_q.clock_source_select & ctrl_q.gated_accumulate_en;
        // synchronised edges wait for the next internal tick; a new edge beats consumption
        pend_d    = ctrl_q.run & (pin_rise | (pend_q & ~int_tick));
        if (ctrl_q.ext_clock_sync) begin
            ext_tick = pend_q & int_tick;
        end else begin
            ext_tick = pin_rise;
        end
        if (!ctrl_q.run || halted) begin
            pl.src_tick = 1'b0;
        end else if (ctrl_q.clock_source_select) begin
            pl.src_tick = ext_tick;
        end else if (gate_mode) begin
            pl.src_tick = int_tick & pin_level;
        end else begin
            pl.src_tick = int_tick;
        end
        pl.ratio = ctrl_q.prescale_select;
        pl.clear = ~ctrl_q.run | wr_ctrl;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_ph_q <= 1'b0;
            pend_q   <= 1'b0;
        end else begin
            int_ph_q <= int_ph_d;
            pend_q   <= pend_d;
        end
    end

    sbgt_prescaler #(
        .PS_W (8)
    ) u_presc (
        .clk   (clk),
        .rst_n (rst_n),
        .pl    (pl)
    );

    // ==========================================================
    // counter and period compare
    always_comb begin
        count_d   = count_q;
        match_set = 1'b0;
        if (wr_count) begin
            count_d = reg_wdata;
        end else if (pl.tick) begin
            if (count_q == period_q) begin
                count_d   = 16'h0000;
                match_set = 1'b1;
            end else begin
                count_d = count_q + 16'h0001;
            end
        end
        gate_set = ctrl_q.run & ~halted & gate_mode & pin_fall;
    end

    // ==========================================================
    // register file
    always_comb begin
        ctrl_d   = ctrl_q;
        period_d = period_q;
        mask_d   = mask_q;
        if (wr_ctrl) begin
            // only implemented fields are stored
            ctrl_d = sbgt_unpack(reg_wdata & `SBGT_CTRL_WMASK);
        end
        if (wr_period) begin
            period_d = reg_wdata;
        end
        if (wr_mask) begin
            mask_d = reg_wdata & `SBGT_ST_WMASK;
        end
    end

    // ==========================================================
    // interrupt status: set wins over read clear
    always_comb begin
        st_set                = 16'h0000;
        st_set[`SBGT_ST_MATCH] = match_set;
        st_set[`SBGT_ST_GATE]  = gate_set;
        if (rd_status) begin
            status_d = st_set;
        end else begin
            status_d = status_q | st_set;
        end
        irq_d = |(status_d & mask_d);
    end

    // ==========================================================
    // read data, valid in the cycle after the strobe only
    always_comb begin
        rdata_d = 16'h0000;
        if (reg_re) begin
            unique case (reg_addr)
                `SBGT_OFF_CTRL:   rdata_d = sbgt_pack(ctrl_q);
                `SBGT_OFF_COUNT:  rdata_d = count_q;
                `SBGT_OFF_PERIOD: rdata_d = period_q;
                `SBGT_OFF_STATUS: rdata_d = status_q;
                `SBGT_OFF_MASK:   rdata_d = mask_q;
                default:          rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q   <= sbgt_unpack(`SBGT_RST_CTRL);
            count_q  <= `SBGT_RST_COUNT;
            period_q <= `SBGT_RST_PERIOD;
            status_q <= 16'h0000;
            mask_q   <= `SBGT_RST_MASK;
            rdata_q  <= 16'h0000;
            irq_q    <= 1'b0;
        end else begin
            ctrl_q   <= ctrl_d;
            count_q  <= count_d;
            period_q <= period_d;
            status_q <= status_d;
            mask_q   <= mask_d;
            rdata_q  <= rdata_d;
            irq_q    <= irq_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq       = irq_q;
endmodule : sbgt_timer

// >>> rtl/sbgt_map.svh
// register offsets, field positions, reset values and timing counts of the general timer
`ifndef SBGT_MAP_SVH
`define SBGT_MAP_SVH

// ==========================================================
// register offsets
`define SBGT_ADDR_W        8
`define SBGT_OFF_CTRL      8'h00
`define SBGT_OFF_COUNT     8'h04
`define SBGT_OFF_PERIOD    8'h08
`define SBGT_OFF_STATUS    8'h0c
`define SBGT_OFF_MASK      8'h10

// ==========================================================
// control field positions
`define SBGT_BIT_RUN       15
`define SBGT_BIT_IDLE      13
`define SBGT_BIT_GATE      6
`define SBGT_BIT_PS_HI     5
`define SBGT_BIT_PS_LO     4
`define SBGT_BIT_SYNC      2
`define SBGT_BIT_CS        1
`define SBGT_CTRL_WMASK    16'ha076

// ==========================================================
// status field positions
`define SBGT_ST_MATCH      0
`define SBGT_ST_GATE       1
`define SBGT_ST_WMASK      16'h0003

// ==========================================================
// reset values
`define SBGT_RST_CTRL      16'h0000
`define SBGT_RST_COUNT     16'h0000
`define SBGT_RST_PERIOD    16'hffff
`define SBGT_RST_MASK      16'h0000

// ==========================================================
// timing counts
`define SBGT_INT_DIV       2
`define SBGT_PS_LIM_1      8'h00
`define SBGT_PS_LIM_8      8'h07
`define SBGT_PS_LIM_64     8'h3f
`define SBGT_PS_LIM_256    8'hff

`endif

// >>> rtl/sbgt_pkg.sv
// types and decode functions of the general timer
`include "sbgt_map.svh"

package sbgt_pkg;

    // ==========================================================
    // types
    typedef logic [15:0] sbgt_word_t;

    typedef enum logic [1:0] {
        ps_div1,
        ps_div8,
        ps_div64,
        ps_div256
    } sbgt_ps_e;

    typedef struct packed {
        logic     run;
        logic     idle_halt;
        logic     gated_accumulate_en;
        sbgt_ps_e prescale_select;
        logic     ext_clock_sync;
        logic     clock_source_select;
    } sbgt_ctrl_s;

    // ==========================================================
    // functions
    function automatic sbgt_ctrl_s sbgt_unpack(input sbgt_word_t w);
        sbgt_ctrl_s c;
        c.run                 = w[`SBGT_BIT_RUN];
        c.idle_halt           = w[`SBGT_BIT_IDLE];
        c.gated_accumulate_en = w[`SBGT_BIT_GATE];
        c.prescale_select     = sbgt_ps_e'(w[`SBGT_BIT_PS_HI:`SBGT_BIT_PS_LO]);
        c.ext_clock_sync      = w[`SBGT_BIT_SYNC];
        c.clock_source_select = w[`SBGT_BIT_CS];
        return c;
    endfunction

    function automatic sbgt_word_t sbgt_pack(input sbgt_ctrl_s c);
        sbgt_word_t w;
        w                                   = 16'h0000;
        w[`SBGT_BIT_RUN]                    = c.run;
        w[`SBGT_BIT_IDLE]                   = c.idle_halt;
        w[`SBGT_BIT_GATE]                   = c.gated_accumulate_en;
        w[`SBGT_BIT_PS_HI:`SBGT_BIT_PS_LO]  = c.prescale_select;
        w[`SBGT_BIT_SYNC]                   = c.ext_clock_sync;
        w[`SBGT_BIT_CS]                     = c.clock_source_select;
        return w;
    endfunction

    function automatic logic [7:0] sbgt_ps_limit(input sbgt_ps_e ps);
        logic [7:0] lim;
        lim = `SBGT_PS_LIM_1;
        unique case (ps)
            ps_div1:   lim = `SBGT_PS_LIM_1;
            ps_div8:   lim = `SBGT_PS_LIM_8;
            ps_div64:  lim = `SBGT_PS_LIM_64;
            ps_div256: lim = `SBGT_PS_LIM_256;
        endcase
        return lim;
    endfunction

endpackage : sbgt_pkg

// >>> rtl/sbgt_presc_if.sv
// link between timer core and its prescaler
interface sbgt_presc_if;
    import sbgt_pkg::*;

    logic     src_tick;
    logic     clear;
    sbgt_ps_e ratio;
    logic     tick;

    modport core  (output src_tick, output clear, output ratio, input tick);
    modport presc (input src_tick, input clear, input ratio, output tick);
endinterface : sbgt_presc_if

// >>> rtl/sbgt_pin_sync.sv
// two-flop pin synchroniser with edge detection
module sbgt_pin_sync #(
    parameter int STAGES = 2
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // pin side
    input  wire logic pin,
    // synchronised side
    output logic      level,
    output logic      rise,
    output logic      fall
);
    generate
        if (STAGES < 2) begin : g_chk
            $error("sbgt_pin_sync needs at least two stages");
        end
    endgenerate

    logic [STAGES-1:0] sync_q;
    logic [STAGES-1:0] sync_d;
    logic              prev_q;
    logic              prev_d;

    // ==========================================================
    // synchroniser chain
    genvar i;
    generate
        for (i = 0; i < STAGES; i++) begin : g_stage
            if (i == 0) begin : g_first
                assign sync_d[i] = pin;
            end else begin : g_next
                assign sync_d[i] = sync_q[i-1];
            end
        end
    endgenerate

    always_comb begin
        prev_d = sync_q[STAGES-1];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_q <= '0;
            prev_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    assign level = sync_q[STAGES-1];
    assign rise  = sync_q[STAGES-1] & ~prev_q;
    assign fall  = ~sync_q[STAGES-1] & prev_q;
endmodule : sbgt_pin_sync

// >>> rtl/sbgt_prescaler.sv
// input clock prescaler of 1, 8, 64 or 256
module sbgt_prescaler #(
    parameter int PS_W = 8
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // core link
    sbgt_presc_if.presc pl
);
    import sbgt_pkg::*;

    generate
        if (PS_W < 8) begin : g_chk
            $error("sbgt_prescaler needs at least 8 bits for divide by 256");
        end
    endgenerate

    logic [PS_W-1:0] cnt_q;
    logic [PS_W-1:0] cnt_d;
    logic [PS_W-1:0] lim;

    always_comb begin
        lim     = PS_W'(sbgt_ps_limit(pl.ratio));
        cnt_d   = cnt_q;
        pl.tick = 1'b0;
        if (pl.clear) begin
            cnt_d = '0;
        end else if (pl.src_tick) begin
            if (cnt_q >= lim) begin
                cnt_d   = '0;
                pl.tick = 1'b1;
            end else begin
                cnt_d = cnt_q + PS_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : sbgt_prescaler

// >>> verif/sbgt_timer_properties.sv
// concurrent checks of the general timer register port and interrupt
`include "sbgt_map.svh"

module sbgt_timer_properties (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 rst_n,
    // register port
    input wire logic [7:0]           reg_addr,
    input wire sbgt_pkg::sbgt_word_t reg_wdata,
    input wire logic                 reg_we,
    input wire logic                 reg_re,
    input wire sbgt_pkg::sbgt_word_t reg_rdata,
    // pins and power
    input wire logic                 ext_clock_pin,
    input wire logic                 cpu_idle,
    input wire logic                 cpu_sleep,
    // interrupt
    input wire logic                 irq
);
    import sbgt_pkg::*;
    // ==========================================================
    // shadow registers
    sbgt_word_t ctrl_q, ctrl_d, per_q, per_d, cnt_q, cnt_d;
    logic [1:0] mask_q, mask_d;
    logic       ok_q, ok_d, clr, known, rd_st, rd_cn;
    assign rd_st = reg_re && reg_addr == `SBGT_OFF_STATUS;
    assign rd_cn = reg_re && reg_addr == `SBGT_OFF_COUNT;
    assign clr   = rd_st || (reg_we && reg_addr inside {`SBGT_OFF_MASK, `SBGT_OFF_STATUS});
    assign known = reg_addr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    always_comb begin
        ctrl_d = ctrl_q;
        per_d  = per_q;
        cnt_d  = cnt_q;
        mask_d = mask_q;
        ok_d   = ok_q && !(reg_we && reg_addr == `SBGT_OFF_CTRL);
        if (reg_we && reg_addr == `SBGT_OFF_CTRL) ctrl_d = reg_wdata & `SBGT_CTRL_WMASK;
        if (reg_we && reg_addr == `SBGT_OFF_PERIOD) per_d = reg_wdata;
        if (reg_we && reg_addr == `SBGT_OFF_MASK) mask_d = reg_wdata[1:0];
        if (reg_we && reg_addr == `SBGT_OFF_COUNT) begin
            cnt_d = reg_wdata;
            ok_d  = !ctrl_q[`SBGT_BIT_RUN];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `SBGT_RST_CTRL;
            per_q  <= `SBGT_RST_PERIOD;
            cnt_q  <= `SBGT_RST_COUNT;
            mask_q <= 2'h0;
            ok_q   <= 1'b1;
        end else begin
            ctrl_q <= ctrl_d;
            per_q  <= per_d;
            cnt_q  <= cnt_d;
            mask_q <= mask_d;
            ok_q   <= ok_d;
        end
    end
    // ==========================================================
    // assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_rdata_rest_zero: assert property (!reg_re |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    a_unmapped_reads_zero: assert property (reg_re && !known |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_ctrl_readback: assert property (reg_re && reg_addr == `SBGT_OFF_CTRL |=> reg_rdata == ctrl_q)
        else $error("control readback wrong");
    a_period_readback: assert property (reg_re && reg_addr == `SBGT_OFF_PERIOD |=> reg_rdata == per_q)
        else $error("period readback wrong");
    a_mask_readback: assert property (reg_re && reg_addr == `SBGT_OFF_MASK |=> reg_rdata == {14'h0000, mask_q})
        else $error("mask readback wrong");
    a_count_holds_stopped: assert property (rd_cn && ok_q |=> reg_rdata == cnt_q)
        else $error("count moved while stopped");
    a_irq_masked_off: assert property (mask_q == 2'h0 && !(reg_we && reg_addr == `SBGT_OFF_MASK) |=> !irq)
        else $error("interrupt with all sources masked");
    a_irq_sticky: assert property (irq && !clr && !$past(clr) |=> irq)
        else $error("interrupt dropped without clearing");
    a_status_read_clears: assert property (rd_st && !ctrl_q[15] && !$past(ctrl_q[15]) ##2 rd_st && !ctrl_q[15]
        |=> reg_rdata == 16'h0000)
        else $error("status not cleared by read");
    c_irq_rise: cover property ($rose(irq));
    c_gate_event: cover property (rd_st ##1 reg_rdata[`SBGT_ST_GATE]);
    c_count_wrap: cover property (rd_cn ##1 reg_rdata == 16'h0000 && per_q == 16'h0002);
endmodule // sbgt_timer_properties

bind sbgt_timer sbgt_timer_properties u_props (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
    .ext_clock_pin, .cpu_idle, .cpu_sleep, .irq);

// >>> verif/sbgt_timer_tb.sv
// self-checking bench of the general timer
`include "sbgt_map.svh"

module sbgt_timer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sbgt_pkg::*;
    localparam logic [7:0] A_CT = `SBGT_OFF_CTRL;
    localparam logic [7:0] A_CN = `SBGT_OFF_COUNT;
    localparam logic [7:0] A_PR = `SBGT_OFF_PERIOD;
    localparam logic [7:0] A_ST = `SBGT_OFF_STATUS;
    localparam logic [7:0] A_MK = `SBGT_OFF_MASK;
    logic       clk, rst_n, reg_we, reg_re, ext_clock_pin, cpu_idle, cpu_sleep, irq;
    logic [7:0] reg_addr;
    sbgt_word_t reg_wdata, reg_rdata, rv, e;
    int         n_errors, cmp_count;

    sbgt_timer dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
        .ext_clock_pin, .cpu_idle, .cpu_sleep, .irq);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ==========================================================
    // bus and compare tasks
    task automatic wr(input logic [7:0] a, input sbgt_word_t d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_we    <= 1'b1;
        @(posedge clk);
        reg_we    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_re   <= 1'b1;
        @(posedge clk);
        reg_re   <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask
    task automatic chk_rng(input sbgt_word_t lo, input sbgt_word_t hi, input sbgt_word_t g);
        cmp_count++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            n_errors++;
            $display("ERROR %0t value %h outside %h..%h", $time, g, lo, hi);
        end
    endtask
    task automatic chk_b(input logic x, input logic g);
        cmp_count++;
        if (g !== x) begin
            n_errors++;
            $display("ERROR %0t irq %b expected %b", $time, g, x);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input sbgt_word_t lo, input sbgt_word_t hi);
        rd(a);
        chk_rng(lo, hi, rv);
    endtask
    task automatic edges(input int n);
        repeat (n) begin
            @(posedge clk);
            ext_clock_pin <= 1'b1;
            repeat (4) @(posedge clk);
            ext_clock_pin <= 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (8) @(posedge clk);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs();
        rdchk(A_CT, 16'h0000, 16'h0000);
        rdchk(A_PR, 16'hffff, 16'hffff);
        rdchk(A_ST, 16'h0000, 16'h0000);
        wr(A_CT, 16'h5f89);
        rdchk(A_CT, 16'h0000, 16'h0000);
        wr(A_CT, 16'h2076);
        rdchk(A_CT, 16'h2076, 16'h2076);
        wr(A_CT, 16'h0000);
        wr(8'h14, 16'hffff);
        rdchk(8'h14, 16'h0000, 16'h0000);
        $display("t_regs done");
    endtask
    task automatic t_period();
        wr(A_CT, 16'h8000);
        wr(A_PR, 16'h0002);
        wr(A_MK, 16'h0001);
        rd(A_CN);
        e = rv;
        repeat (8) begin
            e = (e == 16'h0002) ? 16'h0000 : e + 16'h0001;
            rdchk(A_CN, e, e);
        end
        wr(A_CT, 16'h0000);
        chk_b(1'b1, irq);
        wr(A_MK, 16'h0000);
        @(posedge clk);
        #1;
        chk_b(1'b0, irq);
        rdchk(A_ST, 16'h0001, 16'h0001);
        rdchk(A_ST, 16'h0000, 16'h0000);
        wr(A_CN, 16'h0005);
        repeat (20) @(posedge clk);
        rdchk(A_CN, 16'h0005, 16'h0005);
        $display("t_period done");
    endtask
    task automatic t_prescale();
        sbgt_word_t ex[4] = '{16'h0400, 16'h0080, 16'h0010, 16'h0004};
        wr(A_PR, 16'hffff);
        for (int c = 0; c < 4; c++) begin
            wr(A_CN, 16'h0000);
            wr(A_CT, 16'h8000 | 16'(c << 4));
            repeat (2046) @(posedge clk);
            wr(A_CT, 16'h0000);
            rdchk(A_CN, ex[c] - 16'h0001, ex[c] + 16'h0001);
        end
        wr(A_CN, 16'h0000);
        repeat (30) begin
            wr(A_CT, 16'h8010);
            repeat (8) @(posedge clk);
        end
        wr(A_CT, 16'h0000);
        rdchk(A_CN, 16'h0000, 16'h0000);
        $display("t_prescale done");
    endtask
    task automatic t_gate();
        wr(A_CN, 16'h0000);
        wr(A_MK, 16'h0002);
        wr(A_CT, 16'h8040);
        repeat (100) @(posedge clk);
        rdchk(A_CN, 16'h0000, 16'h0000);
        ext_clock_pin <= 1'b1;
        repeat (200) @(posedge clk);
        ext_clock_pin <= 1'b0;
        repeat (10) @(posedge clk);
        wr(A_CT, 16'h0000);
        rdchk(A_CN, 16'h0062, 16'h0066);
        chk_b(1'b1, irq);
        rdchk(A_ST, 16'h0002, 16'h0002);
        $display("t_gate done");
    endtask
    task automatic t_ext();
        wr(A_CN, 16'h0000);
        wr(A_CT, 16'h8042);
        edges(20);
        rdchk(A_CN, 16'h0014, 16'h0014);
        cpu_sleep <= 1'b1;
        edges(10);
        rdchk(A_CN, 16'h001e, 16'h001e);
        wr(A_CT, 16'h8006);
        edges(10);
        rdchk(A_CN, 16'h001e, 16'h001e);
        cpu_sleep <= 1'b0;
        edges(10);
        rdchk(A_CN, 16'h0028, 16'h0029);
        wr(A_CT, 16'h0000);
        $display("t_ext done");
    endtask
    task automatic t_idle();
        wr(A_CN, 16'h0000);
        cpu_idle <= 1'b1;
        wr(A_CT, 16'ha000);
        repeat (100) @(posedge clk);
        rdchk(A_CN, 16'h0000, 16'h0000);
        wr(A_CT, 16'h8000);
        repeat (98) @(posedge clk);
        wr(A_CT, 16'h0000);
        rdchk(A_CN, 16'h0031, 16'h0033);
        cpu_idle <= 1'b0;
        $display("t_idle done");
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        rst_n         = 1'b0;
        reg_addr      = 8'h00;
        reg_wdata     = 16'h0000;
        reg_we        = 1'b0;
        reg_re        = 1'b0;
        ext_clock_pin = 1'b0;
        cpu_idle      = 1'b0;
        cpu_sleep     = 1'b0;
        n_errors      = 0;
        cmp_count     = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_period();
        t_prescale();
        t_gate();
        t_ext();
        t_idle();
        finish_test();
    end
    initial begin
        #200000;
        n_errors++;
        $display("ERROR %0t watchdog expired", $time);
        finish_test();
    end
endmodule // sbgt_timer_tb
